// ===== uart_channel.sv
// One asynchronous serial channel: register decode, transmit queue and shifter,
// receive shifter and queue with error tags, time-out, loopback.
// Assumes bus strobes and serial inputs are synchronous to REF_CLK.
//
// Operation
// - Transmit the lowest data bit first after the start bit.
// - With queuing on, each transmit write pushes one byte into the 16-entry queue; a write to a full queue is dropped.
// - Without queuing, holding-empty sets when the byte moves into the shifter.
// - Holding-empty raises the transmit interrupt only when its enable is set.
// - Without queuing, shifter-empty sets once the shifter has fully emptied.
// - With queuing, accept 16 bytes; holding-empty whenever the queue is empty.
// - With queuing, shifter-empty only when queue and shifter are both empty.
// - After a falling edge, sample at count 8; accept start only if still low.
// - Sample every data and stop bit at mid-bit with the same counting.
// - Receive queue holds 16 entries of 8 data bits plus three error tags.
// - Each receive read advances the queue and refreshes error status bits.
// - Receive interrupt on each character or at the trigger level, when enabled.
// - With queuing, time-out interrupt after four words plus 12 bit times without a character.
// - With queuing, receive reads return characters oldest first.
// - Loopback bit routes the shifter output into the receiver; all else works.
// - In loopback the serial output idles high, modem outputs off, inputs ignored.
// - Three address lines plus chip select and channel pick select a register.
// - Offset 0 is receive/transmit data, or low divisor with divisor access set.
// - Offsets 1 and 2 switch between divisor high/alternate and enable/status/queue.
// - Offsets 3 to 7 are fixed; writes to line and modem status are ignored.
// - One bit period is exactly 16 ticks of the 16X clock.
// - Frame is start, data bits, optional parity, then one or two stop bits.
`default_nettype none
`include "uart_chan_regs.svh"
module uart_channel
  import uart_chan_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter bit CHAN_ID = 1'b0
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CS_N,
  input wire logic CHANNEL_PICK,
  input wire logic [2:0] ADDR,
  input wire logic IOR_N,
  input wire logic IOW_N,
  input wire logic [7:0] D_IN,
  output logic [7:0] D_OUT,
  output logic D_OE,
  input wire logic RX,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic CARRIER_DETECT_N,
  input wire logic RING_INDICATE_N,
  output logic TX,
  output logic RTS_N,
  output logic DTR_N,
  output logic INT
);
  localparam int AW = $clog2(DEPTH);

  // Trigger levels up to 14 need at least 16 entries
  initial begin
    if (DEPTH < 16 || DEPTH != (1 << AW)) begin
      $error("DEPTH must be a power of two of at least 16");
    end
  end

  // Parity over the configured word length; stick parity forces a constant
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lc);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - lc[1:0]));
    if (lc[`LCR_STICK]) begin
      par_bit = ~lc[`LCR_EVEN];
    end else begin
      par_bit = lc[`LCR_EVEN] ? ^m : ~^m;
    end
  endfunction

  logic [7:0] line_control, modem_control, interrupt_enable, queue_control, alternate_function, scratch_pad, dll, divisor_high;
  logic iow_q, ior_q;
  logic [3:0] ra;
  tx_state_t tx_state;
  rx_state_t rx_state;

  // Bus decode: channel pick selects this channel, concurrent write opens both
  wire pick = !CS_N && (CHANNEL_PICK == CHAN_ID);
  wire wr_now = !IOW_N && !CS_N && (CHANNEL_PICK == CHAN_ID || alternate_function[`AFR_CONCURRENT]);
  wire rd_now = !IOR_N && pick;
  wire wr = wr_now && !iow_q;
  // Read side effects act at the end of the strobe so the data stays stable
  wire rd_end = ior_q && !rd_now;
  wire dlab = line_control[`LCR_DIV_ACCESS];
  wire [7:0] wdec = wr ? (8'h01 << ADDR) : 8'h00;
  wire wr_thr = wdec[`OFS_DATA] && !dlab;
  wire wr_dll = wdec[`OFS_DATA] && dlab;
  wire wr_dlm = wdec[`OFS_IER] && dlab;
  wire wr_ier = wdec[`OFS_IER] && !dlab;
  wire wr_afr = wdec[`OFS_ISR] && dlab;
  wire wr_fcr = wdec[`OFS_ISR] && !dlab;
  wire rd_rhr_end = rd_end && ra == {1'b0, `OFS_DATA};
  wire rd_lsr_end = rd_end && ra[2:0] == `OFS_LSR;
  wire rd_msr_end = rd_end && ra[2:0] == `OFS_MSR;
  wire fifo_en = queue_control[`FCR_QUEUE_EN];
  wire loop = modem_control[`MCR_LOOP];
  wire chg_en = wr_fcr && (D_IN[`FCR_QUEUE_EN] != fifo_en);
  wire tx_clr = wr_fcr && (D_IN[`FCR_TX_CLR] || chg_en);
  wire rx_clr = wr_fcr && (D_IN[`FCR_RX_CLR] || chg_en);
  // Without queuing each direction holds a single character
  wire [AW:0] cap = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);

  // Strobe history and latched read address
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      iow_q <= 1'b0;
      ior_q <= 1'b0;
      ra <= 4'h0;
    end else begin
      iow_q <= wr_now;
      ior_q <= rd_now;
      if (rd_now) ra <= {dlab, ADDR};
    end
  end

  // Control registers; line and modem status offsets take no write
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      line_control <= `RST_REG;
      modem_control <= `RST_REG;
      interrupt_enable <= `RST_REG;
      queue_control <= `RST_REG;
      alternate_function <= `RST_REG;
      scratch_pad <= `RST_REG;
      dll <= `RST_DIV_LOW;
      divisor_high <= `RST_REG;
    end else begin
      if (wdec[`OFS_LCR]) line_control <= D_IN;
      if (wdec[`OFS_MCR]) modem_control <= D_IN & `MCR_MASK;
      if (wdec[`OFS_SPR]) scratch_pad <= D_IN;
      if (wr_ier) interrupt_enable <= D_IN & `IER_MASK;
      if (wr_fcr) queue_control <= D_IN & `FCR_MASK;
      if (wr_afr) alternate_function <= D_IN & `AFR_MASK;
      if (wr_dll) dll <= D_IN;
      if (wr_dlm) divisor_high <= D_IN;
    end
  end

  // 16X tick from the divisor; a zero divisor behaves as one
  logic [15:0] baud_cnt;
  wire [15:0] div = {divisor_high, dll};
  wire [15:0] div_m1 = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
  wire tick = baud_cnt >= div_m1;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) baud_cnt <= 16'h0000;
    else baud_cnt <= tick ? 16'h0000 : baud_cnt + 16'h0001;
  end

  // Transmit queue
  logic [7:0] txq [DEPTH];
  logic [AW-1:0] tx_wp, tx_rp;
  logic [AW:0] tx_cnt;
  logic [3:0] tx_phase;
  logic [2:0] tx_idx;
  logic [7:0] tx_byte;
  wire tx_push = wr_thr && (tx_cnt < cap);
  wire tx_pop = tx_state == T_IDLE && tx_cnt != '0 && !tx_clr;
  wire thre = tx_cnt == '0;
  wire temt = thre && tx_state == T_IDLE;
  wire [2:0] last_idx = 3'h4 + {1'b0, line_control[1:0]};
  wire bit_end = tick && tx_phase == `BIT_LAST;

  always_ff @(posedge REF_CLK) begin
    if (tx_push) txq[tx_wp] <= D_IN;
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else if (tx_clr) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      tx_wp <= tx_wp + AW'(tx_push);
      tx_rp <= tx_rp + AW'(tx_pop);
      tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end

  // Transmit shifter: the idle state loads the next byte at once
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_state <= T_IDLE;
      tx_phase <= 4'h0;
      tx_idx <= 3'h0;
      tx_byte <= 8'h00;
    end else if (tx_state == T_IDLE) begin
      tx_phase <= 4'h0;
      if (tx_pop) begin
        tx_byte <= txq[tx_rp];
        tx_state <= T_START;
      end
    end else if (tick) begin
      tx_phase <= tx_phase + 4'h1;
      if (bit_end) begin
        unique case (tx_state)
          T_START: begin
            tx_state <= T_DATA;
            tx_idx <= 3'h0;
          end
          T_DATA: begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == last_idx) begin
              tx_state <= line_control[`LCR_PAR_EN] ? T_PAR : T_STOP;
              tx_idx <= 3'h0;
            end
          end
          T_PAR: tx_state <= T_STOP;
          T_STOP: begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == {2'b00, line_control[`LCR_STOP2]}) tx_state <= T_IDLE;
          end
          default: tx_state <= T_IDLE;
        endcase
      end
    end
  end

  // Serial level before break and loopback
  logic tx_line;
  always_comb begin
    unique case (tx_state)
      T_START: tx_line = 1'b0;
      T_DATA: tx_line = tx_byte[tx_idx];
      T_PAR: tx_line = par_bit(tx_byte, line_control);
      default: tx_line = 1'b1;
    endcase
  end
  wire tx_out = tx_line && !line_control[`LCR_BREAK];

  // Receiver input: loopback takes the shifter output and ignores the pin
  wire rx_in = loop ? tx_out : RX;
  logic rx_prev;
  logic [3:0] rx_phase;
  logic [2:0] rx_idx;
  logic [7:0] rx_byte;
  logic rx_pe;
  wire rx_bit_end = tick && rx_phase == `BIT_LAST;
  wire rx_done = rx_state == R_STOP && rx_bit_end;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_prev <= 1'b1;
      rx_state <= R_IDLE;
      rx_phase <= 4'h0;
      rx_idx <= 3'h0;
      rx_byte <= 8'h00;
      rx_pe <= 1'b0;
    end else begin
      rx_prev <= rx_in;
      unique case (rx_state)
        R_IDLE: begin
          rx_phase <= 4'h0;
          if (rx_prev && !rx_in) rx_state <= R_START;
        end
        R_START: if (tick) begin
          rx_phase <= rx_phase + 4'h1;
          if (rx_phase == `HALF_BIT_LAST) begin
            rx_phase <= 4'h0;
            rx_idx <= 3'h0;
            rx_byte <= 8'h00;
            rx_pe <= 1'b0;
            rx_state <= rx_in ? R_IDLE : R_DATA;
          end
        end
        R_DATA: if (tick) begin
          rx_phase <= rx_phase + 4'h1;
          if (rx_bit_end) begin
            rx_byte[rx_idx] <= rx_in;
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == last_idx) rx_state <= line_control[`LCR_PAR_EN] ? R_PAR : R_STOP;
          end
        end
        R_PAR: if (tick) begin
          rx_phase <= rx_phase + 4'h1;
          if (rx_bit_end) begin
            rx_pe <= rx_in != par_bit(rx_byte, line_control);
            rx_state <= R_STOP;
          end
        end
        R_STOP: if (tick) begin
          rx_phase <= rx_phase + 4'h1;
          if (rx_bit_end) rx_state <= R_IDLE;
        end
        default: rx_state <= R_IDLE;
      endcase
    end
  end

  // Receive queue entries: break, framing, parity, data
  logic [10:0] rxq [DEPTH];
  logic [AW-1:0] rx_wp, rx_rp;
  logic [AW:0] rx_cnt;
  logic overrun;
  wire rx_full = rx_cnt >= cap;
  wire rx_push = rx_done && !rx_full && !rx_clr;
  wire rx_pop = rd_rhr_end && rx_cnt != '0 && !rx_clr;
  wire [10:0] head = rxq[rx_rp];
  wire [2:0] tags = (rx_cnt != '0) ? head[10:8] : 3'h0;
  wire fe_now = !rx_in;
  wire [10:0] rx_entry = {fe_now && rx_byte == 8'h00 && !rx_pe, fe_now, rx_pe, rx_byte};

  always_ff @(posedge REF_CLK) begin
    if (rx_push) rxq[rx_wp] <= rx_entry;
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else if (rx_clr) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      rx_wp <= rx_wp + AW'(rx_push);
      rx_rp <= rx_rp + AW'(rx_pop);
      rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  // Overrun is sticky until a status read; a new overrun wins over the clear
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) overrun <= 1'b0;
    else overrun <= (rx_done && rx_full) || (overrun && !rd_lsr_end);
  end

  // Time-out counts 16X ticks with queuing on while unread data waits and nothing arrives
  logic [9:0] to_cnt;
  wire [9:0] to_limit = 10'((`TO_WORDS * (5 + int'(line_control[1:0])) + `TO_EXTRA_BITS)
                            * `TICKS_PER_BIT);
  wire to_flag = to_cnt >= to_limit;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) to_cnt <= 10'h000;
    else if (rx_cnt == '0 || rx_push || rx_pop || !fifo_en) to_cnt <= 10'h000;
    else if (tick && !to_flag) to_cnt <= to_cnt + 10'h001;
  end

  // Trigger level picked by the queue control bits
  wire [AW:0] trig = (queue_control[7:6] == 2'h0) ? (AW+1)'(1) :
                     (queue_control[7:6] == 2'h1) ? (AW+1)'(4) :
                     (queue_control[7:6] == 2'h2) ? (AW+1)'(8) : (AW+1)'(14);
  wire rx_lvl = fifo_en ? (rx_cnt >= trig) : (rx_cnt != '0);

  // Modem inputs are ignored in loopback; deltas clear on a status read
  logic [3:0] mprev, mdelta;
  wire [3:0] mstat = loop ? 4'h0 : ~{CARRIER_DETECT_N, RING_INDICATE_N, DSR_N, CTS_N};
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mprev <= 4'h0;
      mdelta <= 4'h0;
    end else begin
      mprev <= mstat;
      mdelta <= (mstat ^ mprev) | (mdelta & ~{4{rd_msr_end}});
    end
  end

  // Interrupt priority: line, receive data, time-out, transmit, modem
  wire ls_int = interrupt_enable[`IER_LINE] && (overrun || tags != 3'h0);
  wire rx_int = interrupt_enable[`IER_RX] && rx_lvl;
  wire to_int = interrupt_enable[`IER_RX] && to_flag;
  wire tx_int = interrupt_enable[`IER_TX] && thre;
  wire ms_int = interrupt_enable[`IER_MODEM] && mdelta != 4'h0;
  wire [3:0] isr_id = ls_int ? `ISR_LINE : rx_int ? `ISR_RXDATA : to_int ? `ISR_TIMEOUT :
                      tx_int ? `ISR_TXEMPTY : ms_int ? `ISR_MODEM : `ISR_NONE;
  wire [7:0] line_status = {fifo_en && tags != 3'h0, temt, thre, tags, overrun, rx_cnt != '0};

  // Read selection by offset and divisor access
  logic [7:0] rmap [8];
  assign rmap[0] = dlab ? dll : head[7:0];
  assign rmap[1] = dlab ? divisor_high : interrupt_enable;
  assign rmap[2] = dlab ? alternate_function : {fifo_en, fifo_en, 2'b00, isr_id};
  assign rmap[3] = line_control;
  assign rmap[4] = modem_control;
  assign rmap[5] = line_status;
  assign rmap[6] = {mstat, mdelta};
  assign rmap[7] = scratch_pad;

  // Pins from flip-flops; loopback holds the line at mark and modem outputs off
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      D_OUT <= 8'h00;
      D_OE <= 1'b0;
      TX <= 1'b1;
      RTS_N <= 1'b1;
      DTR_N <= 1'b1;
      INT <= 1'b0;
    end else begin
      D_OUT <= rd_now ? rmap[ADDR] : 8'h00;
      D_OE <= rd_now;
      TX <= loop || tx_out;
      RTS_N <= loop || !modem_control[`MCR_RTS];
      DTR_N <= loop || !modem_control[`MCR_DTR];
      INT <= isr_id != `ISR_NONE;
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  a_tx_queue_push: assert property (tx_push && !tx_pop && !tx_clr |=>
    tx_cnt == $past(tx_cnt) + 1'b1) else $error("transmit queue push lost");
  a_thr_load_empty: assert property (tx_pop && !fifo_en && !wr_thr |=> thre)
    else $error("holding empty not set on load");
  a_temt_both: assert property (temt |-> tx_cnt == '0 && tx_state == T_IDLE)
    else $error("shifter empty while busy");
  a_first_bit: assert property (tx_state == T_START && bit_end && !loop && !line_control[6]
    |=> ##1 TX == tx_byte[0]) else $error("first data bit not bit zero");
  a_start_reject: assert property (rx_state == R_START && tick && rx_phase == 4'h7
    && rx_in |=> rx_state == R_IDLE) else $error("false start accepted");
  a_bit_period: assert property ($rose(tx_state == T_DATA) |->
    tx_phase == 4'h0 && tx_idx == 3'h0) else $error("bit period broken");
  a_overrun_drop: assert property (rx_done && rx_full && !rx_pop && !rx_clr |=>
    overrun && rx_cnt == $past(rx_cnt)) else $error("overrun not reported");
  a_rx_pop: assert property (rx_pop && !rx_push |=>
    rx_cnt == $past(rx_cnt) - 1'b1) else $error("receive pop lost");
  a_loop_pins: assert property (loop |=> TX && RTS_N && DTR_N)
    else $error("loopback pins not idle");
  a_timeout_data: assert property (to_int |-> rx_cnt != '0)
    else $error("time-out with empty queue");
endmodule
`default_nettype wire

// ===== uart_chan_regs.svh
// Register offsets, field positions, reset values and bit timing of one channel.
// Included by the channel module and by the bench; definitions only.
`ifndef UART_CHAN_REGS_SVH
`define UART_CHAN_REGS_SVH
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_ISR 3'h2
`define OFS_LCR 3'h3
`define OFS_MCR 3'h4
`define OFS_LSR 3'h5
`define OFS_MSR 3'h6
`define OFS_SPR 3'h7
`define LCR_DIV_ACCESS 7
`define LCR_BREAK 6
`define LCR_STICK 5
`define LCR_EVEN 4
`define LCR_PAR_EN 3
`define LCR_STOP2 2
`define MCR_LOOP 4
`define MCR_RTS 1
`define MCR_DTR 0
`define FCR_QUEUE_EN 0
`define FCR_RX_CLR 1
`define FCR_TX_CLR 2
`define IER_RX 0
`define IER_TX 1
`define IER_LINE 2
`define IER_MODEM 3
`define AFR_CONCURRENT 0
`define IER_MASK 8'h0F
`define FCR_MASK 8'hC9
`define MCR_MASK 8'h1F
`define AFR_MASK 8'h07
`define RST_REG 8'h00
`define RST_DIV_LOW 8'h01
`define HALF_BIT_LAST 4'h7
`define BIT_LAST 4'hF
`define TO_WORDS 4
`define TO_EXTRA_BITS 12
`define TICKS_PER_BIT 16
`define ISR_NONE 4'h1
`define ISR_LINE 4'h6
`define ISR_RXDATA 4'h4
`define ISR_TIMEOUT 4'hC
`define ISR_TXEMPTY 4'h2
`define ISR_MODEM 4'h0
`endif

// ===== uart_chan_pkg.sv
// Types shared by the serial channel: shifter state codes.
// Assumes nothing beyond the register header.
`default_nettype none
package uart_chan_pkg;
  // Gray codes along idle, start, data, parity, stop
  typedef enum logic [2:0] {
    T_IDLE = 3'h0, T_START = 3'h1, T_DATA = 3'h3, T_PAR = 3'h2, T_STOP = 3'h6
  } tx_state_t;
  typedef enum logic [2:0] {
    R_IDLE = 3'h0, R_START = 3'h1, R_DATA = 3'h3, R_PAR = 3'h2, R_STOP = 3'h6
  } rx_state_t;
endpackage
`default_nettype wire

// ===== uart_line_model.sv
// Remote serial line model: sends 8-bit one-stop frames into the channel
// and decodes the channel's transmit output at mid-bit.
// Assumes divisor 1, so one bit lasts 16 clk cycles.
`default_nettype none
module uart_line_model (
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got_q [$];
  logic [7:0] shift;
  int i;

  // Line idles at mark and stays there through loopback, so no false break
  initial rx_line = 1'b1;

  // One frame: start, data LSB first, chosen stop level, then one idle bit
  task automatic send_byte(input logic [7:0] d, input logic stop_bit);
    logic [9:0] frame;
    frame = {stop_bit, d, 1'b0};
    for (int b = 0; b < 11; b++) begin
      @(posedge clk);
      rx_line <= (b < 10) ? frame[b] : 1'b1;
      repeat (15) @(posedge clk);
    end
  endtask

  // Short low pulse that a receiver must reject
  task automatic glitch(input int n);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (n) @(posedge clk);
    rx_line <= 1'b1;
  endtask

  // Decoder; a frame with a bad start or stop is lost, so counts expose it
  always begin
    @(posedge clk);
    if (tx_line === 1'b0) begin
      repeat (8) @(posedge clk);
      if (tx_line === 1'b0) begin
        for (i = 0; i < 8; i++) begin
          repeat (16) @(posedge clk);
          shift[i] = tx_line;
        end
        repeat (16) @(posedge clk);
        if (tx_line === 1'b1) begin
          got_q.push_back(shift);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== dual_uart_channel_datapath_bench.sv
// Self-checking bench of one serial channel: register decode, transmit,
// receive with error tags, overrun, time-out and loopback.
// Assumes divisor 1 after reset, so one bit lasts 16 REF_CLK cycles.
`default_nettype none
`include "uart_chan_regs.svh"
module dual_uart_channel_datapath_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic CS_N = 1'b1;
  logic CHANNEL_PICK = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic IOR_N = 1'b1;
  logic IOW_N = 1'b1;
  logic [7:0] D_IN = 8'h00;
  logic [7:0] D_OUT;
  logic D_OE, RX, TX, RTS_N, DTR_N, INT;
  // Modem inputs as {carrier, ring, ready, clear}, all active low
  logic [3:0] modem_n = 4'hF;
  int num_errors = 0;
  int samples_checked = 0;
  int k;
  logic [7:0] rd;
  logic rd_oe;
  logic [7:0] pat [0:16];

  always #50 REF_CLK = ~REF_CLK;

  // Modem inputs are driven so that status and loopback masking are seen
  uart_channel #(.DEPTH(16), .CHAN_ID(1'b0)) dut_u (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .CS_N(CS_N), .CHANNEL_PICK(CHANNEL_PICK),
    .ADDR(ADDR), .IOR_N(IOR_N), .IOW_N(IOW_N), .D_IN(D_IN), .D_OUT(D_OUT),
    .D_OE(D_OE), .RX(RX), .CTS_N(modem_n[0]), .DSR_N(modem_n[1]),
    .CARRIER_DETECT_N(modem_n[3]), .RING_INDICATE_N(modem_n[2]), .TX(TX),
    .RTS_N(RTS_N), .DTR_N(DTR_N), .INT(INT)
  );
  uart_line_model line_u (.clk(REF_CLK), .tx_line(TX), .rx_line(RX));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Write cycle: strobe low for one edge, then released for at least one
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    CS_N <= 1'b0;
    IOW_N <= 1'b0;
    ADDR <= a;
    D_IN <= d;
    @(posedge REF_CLK);
    CS_N <= 1'b1;
    IOW_N <= 1'b1;
  endtask

  // Read cycle; trailing idle edges let the pop after release land
  task automatic rdreg(input logic [2:0] a);
    @(posedge REF_CLK);
    CS_N <= 1'b0;
    IOR_N <= 1'b0;
    ADDR <= a;
    repeat (2) @(posedge REF_CLK);
    rd = D_OUT;
    rd_oe = D_OE;
    CS_N <= 1'b1;
    IOR_N <= 1'b1;
    repeat (2) @(posedge REF_CLK);
  endtask

  task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
    rdreg(a);
    check(what, rd, exp);
  endtask

  // Bounded wait for decoded frames; running out ends the run
  task automatic wait_got(input int n);
    k = 0;
    while (line_u.got_q.size() < n && k < 4000) begin
      @(posedge REF_CLK);
      k++;
    end
    if (k >= 4000) begin
      check("frame count", 8'(line_u.got_q.size()), 8'(n));
      test_done();
    end
  endtask

  initial begin
    void'($urandom(32'h04d29407));
    for (int i = 0; i < 17; i++) begin
      pat[i] = 8'($urandom);
    end
    repeat (20) @(posedge REF_CLK);
    RESETN <= 1'b1;
    // Reset state and fixed register map
    check("tx idle", {7'h00, TX}, 8'h01);
    rchk("line_status", `OFS_LSR, 8'h60);
    rchk("interrupt_status", `OFS_ISR, 8'h01);
    wr(`OFS_LCR, 8'h03);
    rchk("line_control", `OFS_LCR, 8'h03);
    wr(`OFS_SPR, pat[0]);
    rchk("scratch_pad", `OFS_SPR, pat[0]);
    wr(`OFS_LSR, 8'hFF);
    rchk("line_status ro", `OFS_LSR, 8'h60);
    wr(`OFS_IER, 8'h04);
    // Divisor window swaps offsets 0 to 2, then swaps back
    wr(`OFS_LCR, 8'h83);
    wr(`OFS_DATA, 8'h01);
    wr(`OFS_IER, 8'h00);
    wr(`OFS_ISR, 8'h06);
    rchk("divisor_low", `OFS_DATA, 8'h01);
    rchk("alternate_function", `OFS_ISR, 8'h06);
    wr(`OFS_LCR, 8'h03);
    rchk("interrupt_enable", `OFS_IER, 8'h04);
    rchk("status not alt", `OFS_ISR, 8'h01);
    // Other channel picked: no write, no drive
    @(posedge REF_CLK);
    CHANNEL_PICK <= 1'b1;
    wr(`OFS_SPR, ~pat[0]);
    rdreg(`OFS_SPR);
    check("read enable", {7'h00, rd_oe}, 8'h00);
    CHANNEL_PICK <= 1'b0;
    rchk("scratch kept", `OFS_SPR, pat[0]);
    // Modem status shows the inverted input levels
    modem_n <= 4'($urandom);
    repeat (3) @(posedge REF_CLK);
    rdreg(`OFS_MSR);
    check("modem_status", rd & 8'hF0, {~modem_n, 4'h0});
    // Unqueued transmit with holding-empty interrupt enabled
    wr(`OFS_IER, 8'h02);
    rchk("tx empty id", `OFS_ISR, 8'h02);
    check("int tx empty", {7'h00, INT}, 8'h01);
    wr(`OFS_DATA, pat[1]);
    repeat (4) @(posedge REF_CLK);
    rchk("holding moved", `OFS_LSR, 8'h20);
    wait_got(1);
    repeat (20) @(posedge REF_CLK);
    rchk("shifter empty", `OFS_LSR, 8'h60);
    check("tx byte", line_u.got_q[0], pat[1]);
    wr(`OFS_IER, 8'h00);
    repeat (3) @(posedge REF_CLK);
    check("int masked", {7'h00, INT}, 8'h00);
    // Queued transmit: 17 back to back, shifter plus 16 in the queue
    line_u.got_q.delete();
    wr(`OFS_ISR, 8'h01);
    for (int i = 0; i < 17; i++) begin
      wr(`OFS_DATA, pat[i]);
    end
    rchk("queue busy", `OFS_LSR, 8'h00);
    wait_got(17);
    for (int i = 0; i < 17; i++) begin
      check("queued tx byte", line_u.got_q[i], pat[i]);
    end
    repeat (20) @(posedge REF_CLK);
    rchk("queue drained", `OFS_LSR, 8'h60);
    // Receive with a framing error in the middle entry
    line_u.send_byte(pat[2], 1'b1);
    line_u.send_byte(pat[3] | 8'h01, 1'b0);
    line_u.send_byte(pat[4], 1'b1);
    rchk("rx head clean", `OFS_LSR, 8'h61);
    rchk("rx first", `OFS_DATA, pat[2]);
    rchk("rx head framing", `OFS_LSR, 8'hE9);
    rchk("rx second", `OFS_DATA, pat[3] | 8'h01);
    rchk("rx tags refreshed", `OFS_LSR, 8'h61);
    rchk("rx third", `OFS_DATA, pat[4]);
    line_u.glitch(6);
    repeat (200) @(posedge REF_CLK);
    rchk("false start", `OFS_LSR, 8'h60);
    // Seventeen characters into sixteen places
    for (int i = 0; i < 17; i++) begin
      line_u.send_byte(pat[i], 1'b1);
    end
    rchk("overrun", `OFS_LSR, 8'h63);
    for (int i = 0; i < 16; i++) begin
      rchk("rx order", `OFS_DATA, pat[i]);
    end
    rchk("rx empty", `OFS_LSR, 8'h60);
    // Time-out: trigger at 14, one character, (4*8+12)*16 cycles of silence
    wr(`OFS_ISR, 8'hC1);
    wr(`OFS_IER, 8'h01);
    line_u.send_byte(pat[5], 1'b1);
    repeat (500) @(posedge REF_CLK);
    check("no early int", {7'h00, INT}, 8'h00);
    k = 0;
    while (INT !== 1'b1 && k < 400) begin
      @(posedge REF_CLK);
      k++;
    end
    if (k >= 400) begin
      check("timeout int", {7'h00, INT}, 8'h01);
      test_done();
    end
    rdreg(`OFS_ISR);
    check("timeout id", {4'h0, rd[3:0]}, {4'h0, `ISR_TIMEOUT});
    rchk("timeout data", `OFS_DATA, pat[5]);
    // Unqueued: every character interrupts
    wr(`OFS_ISR, 8'h00);
    line_u.send_byte(pat[6], 1'b1);
    rchk("rx data id", `OFS_ISR, 8'h04);
    check("int rx", {7'h00, INT}, 8'h01);
    rchk("rx data", `OFS_DATA, pat[6]);
    repeat (3) @(posedge REF_CLK);
    check("int cleared", {7'h00, INT}, 8'h00);
    // Loopback: pins parked, character returns internally
    wr(`OFS_IER, 8'h00);
    wr(`OFS_MCR, 8'h03);
    repeat (3) @(posedge REF_CLK);
    check("modem out on", {6'h00, RTS_N, DTR_N}, 8'h00);
    wr(`OFS_MCR, 8'h13);
    repeat (3) @(posedge REF_CLK);
    check("modem out parked", {6'h00, RTS_N, DTR_N}, 8'h03);
    modem_n <= 4'h0;
    repeat (3) @(posedge REF_CLK);
    rdreg(`OFS_MSR);
    check("modem ignored", rd & 8'hF0, 8'h00);
    wr(`OFS_DATA, pat[7]);
    k = 0;
    repeat (200) begin
      @(posedge REF_CLK);
      k += int'(TX !== 1'b1);
    end
    check("tx held mark", 8'(k), 8'h00);
    rchk("loop status", `OFS_LSR, 8'h61);
    rchk("loop data", `OFS_DATA, pat[7]);
    wr(`OFS_MCR, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
